// ===== shared/rmcb_map.svh
`ifndef RMCB_MAP_SVH
`define RMCB_MAP_SVH

`define RMCB_AW          8
`define RMCB_OFF_CTRL    8'h00
`define RMCB_OFF_PGSZ    8'h04
`define RMCB_OFF_DSIZE   8'h08
`define RMCB_OFF_ALEN    8'h0C
`define RMCB_OFF_DESC_HI 8'h10
`define RMCB_OFF_DESC_LO 8'h14
`define RMCB_OFF_STS     8'h18
`define RMCB_STAT_BASE   4'h2
`define RMCB_CTRL_GO     0
`define RMCB_CTRL_PTB    1
`define RMCB_STS_DONE    1
`define RMCB_STS_ERR     2

`define RMCB_N_BIT       31
`define RMCB_FMT_HI      30
`define RMCB_FMT_LO      29
`define RMCB_RSV_BIT     28
`define RMCB_DIR_BIT     27
`define RMCB_SPD_HI      26
`define RMCB_SPD_LO      24
`define RMCB_MPL_HI      23
`define RMCB_MPL_LO      20
`define RMCB_PTB_BIT     19
`define RMCB_PGS_HI      18
`define RMCB_PGS_LO      16
`define RMCB_DSZ_HI      15
`define RMCB_LUN_HI      31
`define RMCB_LUN_LO      29
`define RMCB_RES_HI      28
`define RMCB_RES_LO      25
`define RMCB_AEN_BIT     24
`define RMCB_ALEN_HI     15

`define RMCB_N_VAL       1'h1
`define RMCB_FMT_VAL     2'h0
`define RMCB_RSV_VAL     1'h0
`define RMCB_DIR_VAL     1'h1
`define RMCB_SPD_VAL     3'h2
`define RMCB_MPL_VAL     4'h9
`define RMCB_LUN_VAL     3'h1
`define RMCB_RES_VAL     4'h0
`define RMCB_AEN_VAL     1'h0
`define RMCB_PGS_NONE    3'h0
`define RMCB_DSZ_MIN     16'h0050
`define RMCB_NULL_PTR    32'h80000000

`define RMCB_W_FIRST     3'h0
`define RMCB_W_DESC_HI   3'h2
`define RMCB_W_DESC_LO   3'h3
`define RMCB_W_OPT       3'h4
`define RMCB_W_CMD       3'h5
`define RMCB_W_LAST      3'h7
`define RMCB_STAT_DEPTH  4
`define RMCB_STAT_LIM    3'h4
`define RMCB_STAT_TOP    2'h3

`endif

// ===== shared/rmcb_pkg.sv
`default_nettype none
package rmcb_pkg;
  typedef enum logic [1:0] {RMCB_IDLE, RMCB_SEND, RMCB_WAIT} rmcb_state_e;
  typedef logic [2:0]  rmcb_idx_t;
  typedef logic [31:0] rmcb_word_t;
endpackage
`default_nettype wire

// ===== src/rmcb_orb_fmt.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmcb_map.svh"
module rmcb_orb_fmt (
  input  wire logic                [2:0]  idx,
  input  wire rmcb_pkg::rmcb_word_t       desc_hi,
  input  wire rmcb_pkg::rmcb_word_t       desc_lo,
  input  wire logic                       ptb,
  input  wire logic                [2:0]  pgsz,
  input  wire logic                [15:0] dsize,
  input  wire logic                [15:0] alen,
  output rmcb_pkg::rmcb_word_t            word
);
  // A stale page size left in its register must not leak out when paging is off.
  wire logic [2:0] pgs_eff = ptb ? pgsz : `RMCB_PGS_NONE;

  wire rmcb_pkg::rmcb_word_t opt_word = {
    `RMCB_N_VAL,
    `RMCB_FMT_VAL,
    `RMCB_RSV_VAL,
    `RMCB_DIR_VAL,
    `RMCB_SPD_VAL,
    `RMCB_MPL_VAL,
    ptb,
    pgs_eff,
    dsize
  };

  wire rmcb_pkg::rmcb_word_t cmd_word = {
    `RMCB_LUN_VAL,
    `RMCB_RES_VAL,
    `RMCB_AEN_VAL,
    8'h00,
    alen
  };

  assign word = (idx == `RMCB_W_FIRST)   ? `RMCB_NULL_PTR :
                (idx == `RMCB_W_DESC_HI) ? desc_hi :
                (idx == `RMCB_W_DESC_LO) ? desc_lo :
                (idx == `RMCB_W_OPT)     ? opt_word :
                (idx == `RMCB_W_CMD)     ? cmd_word : 32'h00000000;
endmodule // rmcb_orb_fmt
`default_nettype wire

// ===== src/rmcb_stat_cap.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmcb_map.svh"
module rmcb_stat_cap (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 clr,
  input  wire logic                 push,
  input  wire rmcb_pkg::rmcb_word_t word,
  input  wire logic                 last,
  output rmcb_pkg::rmcb_word_t      q [`RMCB_STAT_DEPTH],
  output logic               [2:0]  cnt,
  output logic                      done
);
  logic [1:0] wr_idx_reg;

  // Words beyond the last slot are dropped rather than wrapping over the header.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_idx_reg <= 2'h0;
      cnt <= 3'h0;
      done <= 1'h0;
    end else if (ce) begin
      done <= push & last;
      if (clr) begin
        wr_idx_reg <= 2'h0;
        cnt <= 3'h0;
      end else if (push && cnt != `RMCB_STAT_LIM) begin
        cnt <= cnt + 3'h1;
        if (wr_idx_reg != `RMCB_STAT_TOP) wr_idx_reg <= wr_idx_reg + 2'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `RMCB_STAT_DEPTH; g = g + 1) begin : g_slot
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) q[g] <= 32'h00000000;
        else if (ce && clr) q[g] <= 32'h00000000;
        else if (ce && push && cnt != `RMCB_STAT_LIM && int'(wr_idx_reg) == g) q[g] <= word;
      end
    end
  endgenerate
endmodule // rmcb_stat_cap
`default_nettype wire

// ===== src/rmcb_host_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmcb_map.svh"
module rmcb_host_ctrl (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic          [31:0] haddr,
  input  wire logic          [1:0]  htrans,
  input  wire logic                 hwrite,
  input  wire logic          [2:0]  hsize,
  input  wire logic          [31:0] hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic               [31:0] hrdata,
  output logic                      hresp,
  output logic                      orb_valid,
  input  wire logic                 orb_ready,
  output rmcb_pkg::rmcb_word_t      orb_word,
  output logic                      orb_last,
  input  wire logic                 stat_valid,
  output logic                      stat_ready,
  input  wire rmcb_pkg::rmcb_word_t stat_word,
  input  wire logic                 stat_last
);
  rmcb_pkg::rmcb_state_e state_reg;
  rmcb_pkg::rmcb_state_e state_next;
  rmcb_pkg::rmcb_idx_t   idx_reg;
  rmcb_pkg::rmcb_idx_t   fmt_idx;
  rmcb_pkg::rmcb_word_t  fmt_word;
  rmcb_pkg::rmcb_word_t  orb_word_reg;
  rmcb_pkg::rmcb_word_t  hrdata_reg;
  rmcb_pkg::rmcb_word_t  desc_hi_reg;
  rmcb_pkg::rmcb_word_t  desc_lo_reg;
  rmcb_pkg::rmcb_word_t  stat_q [`RMCB_STAT_DEPTH];
  logic                  ap_val_reg;
  logic                  ap_wr_reg;
  logic [`RMCB_AW-1:0]   ap_addr_reg;
  logic                  rd_pend_reg;
  logic                  ptb_reg;
  logic [2:0]            pgsz_reg;
  logic [15:0]           dsize_reg;
  logic [15:0]           alen_reg;
  logic                  done_reg;
  logic                  done_next;
  logic                  err_reg;
  logic                  err_next;
  logic [15:0]           orb_cnt_reg;
  logic [2:0]            stat_cnt;
  logic                  stat_done;

  // Bus slave. Writes finish with no wait state; every read taken while the clock enable
  // is high takes one wait state so that a write in the preceding data phase is always seen.
  wire logic acc     = hsel & htrans[1] & hready;
  wire logic wr_en   = ce & ap_val_reg & ap_wr_reg & hready;
  wire logic hit_ctl = ap_addr_reg == `RMCB_OFF_CTRL;
  wire logic hit_pgs = ap_addr_reg == `RMCB_OFF_PGSZ;
  wire logic hit_dsz = ap_addr_reg == `RMCB_OFF_DSIZE;
  wire logic hit_aln = ap_addr_reg == `RMCB_OFF_ALEN;
  wire logic hit_dhi = ap_addr_reg == `RMCB_OFF_DESC_HI;
  wire logic hit_dlo = ap_addr_reg == `RMCB_OFF_DESC_LO;
  wire logic hit_sts = ap_addr_reg == `RMCB_OFF_STS;
  wire logic hit_stq = ap_addr_reg[`RMCB_AW-1:4] == `RMCB_STAT_BASE;

  assign hreadyout = ~rd_pend_reg;
  assign hresp     = 1'h0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ap_val_reg  <= 1'h0;
      ap_wr_reg   <= 1'h0;
      ap_addr_reg <= 8'h00;
      rd_pend_reg <= 1'h0;
    end else if (ce && hready) begin
      ap_val_reg  <= acc;
      ap_wr_reg   <= hwrite;
      ap_addr_reg <= haddr[`RMCB_AW-1:0];
      rd_pend_reg <= acc & ~hwrite;
    end else if (ce) begin
      rd_pend_reg <= 1'h0;
    end
  end

  // Configuration is frozen while a block is in flight, so the words
  // already sent and those still to come belong to the same block.
  wire logic cfg_open = state_reg == rmcb_pkg::RMCB_IDLE;
  wire logic cfg_we   = wr_en & cfg_open;
  wire logic go_req   = wr_en & hit_ctl & hwdata[`RMCB_CTRL_GO] & cfg_open;
  wire logic dsz_ok   = dsize_reg >= `RMCB_DSZ_MIN;
  wire logic start    = go_req & dsz_ok;
  wire logic refuse   = go_req & ~dsz_ok;
  wire logic clr_done = wr_en & hit_sts & hwdata[`RMCB_STS_DONE];
  wire logic clr_err  = wr_en & hit_sts & hwdata[`RMCB_STS_ERR];
  wire logic busy     = ~cfg_open;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ptb_reg     <= 1'h0;
      pgsz_reg    <= 3'h0;
      dsize_reg   <= 16'h0000;
      alen_reg    <= 16'h0000;
      desc_hi_reg <= 32'h00000000;
      desc_lo_reg <= 32'h00000000;
    end else if (cfg_we) begin
      if (hit_ctl) ptb_reg <= hwdata[`RMCB_CTRL_PTB];
      if (hit_pgs) pgsz_reg <= hwdata[2:0];
      if (hit_dsz) dsize_reg <= hwdata[15:0];
      if (hit_aln) alen_reg <= hwdata[15:0];
      if (hit_dhi) desc_hi_reg <= hwdata;
      if (hit_dlo) desc_lo_reg <= hwdata;
    end
  end

  // An event in the same cycle as its clear is kept.
  assign done_next = stat_done | (done_reg & ~clr_done);
  assign err_next  = refuse | (err_reg & ~clr_err);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_reg    <= 1'h0;
      err_reg     <= 1'h0;
      orb_cnt_reg <= 16'h0000;
    end else if (ce) begin
      done_reg <= done_next;
      err_reg  <= err_next;
      if (start) orb_cnt_reg <= orb_cnt_reg + 16'h0001;
    end
  end

  wire rmcb_pkg::rmcb_word_t sts_val =
    {orb_cnt_reg, 9'h000, stat_cnt, 1'h0, err_reg, done_reg, busy};

  wire rmcb_pkg::rmcb_word_t rd_val =
    hit_ctl ? {30'h00000000, ptb_reg, 1'h0} :
    hit_pgs ? {29'h00000000, pgsz_reg} :
    hit_dsz ? {16'h0000, dsize_reg} :
    hit_aln ? {16'h0000, alen_reg} :
    hit_dhi ? desc_hi_reg :
    hit_dlo ? desc_lo_reg :
    hit_sts ? sts_val :
    hit_stq ? stat_q[ap_addr_reg[3:2]] : 32'h00000000;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) hrdata_reg <= 32'h00000000;
    else if (ce && rd_pend_reg) hrdata_reg <= rd_val;
  end

  // Block sequencer. The word register is loaded one step ahead so that
  // the word on the link always comes straight from a flip-flop.
  wire logic xfer     = ce & orb_valid & orb_ready;
  wire logic at_last  = idx_reg == `RMCB_W_LAST;
  wire logic stat_in  = ce & stat_valid & stat_ready;

  assign orb_valid  = state_reg == rmcb_pkg::RMCB_SEND;
  assign orb_last   = orb_valid & at_last;
  assign orb_word   = orb_word_reg;
  assign stat_ready = state_reg == rmcb_pkg::RMCB_WAIT;
  assign fmt_idx    = cfg_open ? `RMCB_W_FIRST : idx_reg + 3'h1;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rmcb_pkg::RMCB_IDLE: begin
        if (start) state_next = rmcb_pkg::RMCB_SEND;
      end
      rmcb_pkg::RMCB_SEND: begin
        if (xfer && at_last) state_next = rmcb_pkg::RMCB_WAIT;
      end
      rmcb_pkg::RMCB_WAIT: begin
        // The target signals completion only through the status block.
        if (stat_done) state_next = rmcb_pkg::RMCB_IDLE;
      end
      default: begin
        state_next = rmcb_pkg::RMCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) state_reg <= rmcb_pkg::RMCB_IDLE;
    else if (ce) state_reg <= state_next;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idx_reg      <= 3'h0;
      orb_word_reg <= 32'h00000000;
    end else if (ce && (start || (xfer && !at_last))) begin
      idx_reg      <= fmt_idx;
      orb_word_reg <= fmt_word;
    end
  end

  rmcb_orb_fmt u_fmt (
    .idx     (fmt_idx),
    .desc_hi (desc_hi_reg),
    .desc_lo (desc_lo_reg),
    .ptb     (ptb_reg),
    .pgsz    (pgsz_reg),
    .dsize   (dsize_reg),
    .alen    (alen_reg),
    .word    (fmt_word)
  );

  rmcb_stat_cap u_stat (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .ce      (ce),
    .clr     (start),
    .push    (stat_in),
    .word    (stat_word),
    .last    (stat_last),
    .q       (stat_q),
    .cnt     (stat_cnt),
    .done    (stat_done)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  wire logic w_opt = xfer & (idx_reg == `RMCB_W_OPT);
  wire logic w_cmd = xfer & (idx_reg == `RMCB_W_CMD);
  wire logic w_dhi = xfer & (idx_reg == `RMCB_W_DESC_HI);

  sequence s_block_end;
    xfer && orb_last;
  endsequence

  sequence s_await_status;
    stat_ready && !orb_valid;
  endsequence

  AST_NOTIFY: assert property (w_opt |-> orb_word[`RMCB_N_BIT] == `RMCB_N_VAL)
    else $error("Completion notify bit not set.");
  AST_STATUS_WAIT: assert property (s_block_end |=> s_await_status)
    else $error("Host not waiting for status after last word.");
  AST_FMT_RSV: assert property (w_opt |-> orb_word[`RMCB_FMT_HI:`RMCB_RSV_BIT] == 3'h0)
    else $error("Request format or reserved bit not zero.");
  AST_DIR: assert property (w_opt |-> orb_word[`RMCB_DIR_BIT] == `RMCB_DIR_VAL)
    else $error("Direction bit not one.");
  AST_SPD: assert property (w_opt |-> orb_word[`RMCB_SPD_HI:`RMCB_SPD_LO] == `RMCB_SPD_VAL)
    else $error("Speed code not two.");
  AST_MPL: assert property (w_opt |-> orb_word[`RMCB_MPL_HI:`RMCB_MPL_LO] == `RMCB_MPL_VAL)
    else $error("Maximum payload code not nine.");
  AST_PAGE: assert property (w_opt && !orb_word[`RMCB_PTB_BIT]
                             |-> orb_word[`RMCB_PGS_HI:`RMCB_PGS_LO] == `RMCB_PGS_NONE)
    else $error("Page size nonzero without page table.");
  AST_DSIZE: assert property (w_opt |-> orb_word[`RMCB_DSZ_HI:0] >= `RMCB_DSZ_MIN)
    else $error("Data size below minimum.");
  AST_REFUSE: assert property (refuse |=> err_reg && !orb_valid)
    else $error("Short data size not refused.");
  AST_LUN: assert property (w_cmd |-> orb_word[`RMCB_LUN_HI:`RMCB_LUN_LO] == `RMCB_LUN_VAL)
    else $error("Logical unit number not one.");
  AST_RES: assert property (w_cmd |-> orb_word[`RMCB_RES_HI:`RMCB_RES_LO] == `RMCB_RES_VAL)
    else $error("Reserved field after unit number not zero.");
  AST_AEN: assert property (w_cmd |-> orb_word[`RMCB_AEN_BIT] == `RMCB_AEN_VAL)
    else $error("Event notification bit not zero.");
  AST_ALEN: assert property (w_cmd |-> orb_word[`RMCB_ALEN_HI:0] == alen_reg)
    else $error("Allocation length differs from its register.");
  AST_DESC: assert property (w_dhi |=> orb_valid && orb_word == desc_lo_reg)
    else $error("Descriptor words out of order.");

  // The word counter runs apart from the sequencer, so a skipped or
  // repeated index shows up when the last word goes out.
  logic [2:0] chk_words_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      chk_words_reg <= 3'h0;
    end else if (start) begin
      chk_words_reg <= 3'h0;
    end else if (xfer) begin
      chk_words_reg <= chk_words_reg + 3'h1;
    end
  end

  wire logic rd_take = ce & acc & ~hwrite;
  wire logic wr_take = ce & acc & hwrite;
  wire logic w_page  = w_opt & orb_word[`RMCB_PTB_BIT];

  sequence s_read_data_phase;
    rd_take ##1 ce;
  endsequence

  sequence s_word_stalled;
    orb_valid && !xfer;
  endsequence

  sequence s_frozen;
    !ce;
  endsequence

  // Reads taken with the clock enable high always pay one wait state and writes none.
  AST_RD_STALL: assert property (rd_take |=> !hreadyout)
    else $error("Read data phase without its wait state.");
  AST_RD_RESUME: assert property (s_read_data_phase |=> hreadyout)
    else $error("Read wait state longer than one cycle.");
  AST_WR_NO_WAIT: assert property (wr_take |=> hreadyout)
    else $error("Write data phase stalled.");
  AST_RD_HOLD: assert property (!(ce && rd_pend_reg) |=> $stable(hrdata))
    else $error("Read data changed outside a read.");

  // With the clock enable low nothing may move, the bus front end included.
  AST_CE_SEQ: assert property (s_frozen |=> $stable(state_reg) && $stable(idx_reg)
                               && $stable(orb_word))
    else $error("Sequencer moved while the clock enable was low.");
  AST_CE_FLAGS: assert property (s_frozen |=> $stable(done_reg) && $stable(err_reg)
                                 && $stable(orb_cnt_reg) && $stable(stat_cnt))
    else $error("Status flags moved while the clock enable was low.");
  AST_CE_BUS: assert property (s_frozen |=> $stable(ap_val_reg) && $stable(rd_pend_reg)
                               && $stable(ptb_reg) && $stable(pgsz_reg))
    else $error("Bus state or settings moved while the clock enable was low.");

  // A block in flight owns its settings and its word until the word is taken.
  AST_CFG_FROZEN: assert property (busy |=> $stable(desc_hi_reg) && $stable(desc_lo_reg)
                                   && $stable(dsize_reg) && $stable(alen_reg))
    else $error("Settings changed while a block was in flight.");
  AST_GO_START: assert property (start |=> orb_valid && orb_word == `RMCB_NULL_PTR)
    else $error("Block did not open with its first word.");
  AST_DESC_HI: assert property (w_dhi |-> orb_word == desc_hi_reg)
    else $error("First descriptor word differs from its register.");
  AST_PTB_PASS: assert property (w_opt |-> orb_word[`RMCB_PTB_BIT] == ptb_reg)
    else $error("Page table flag differs from its register.");
  AST_PAGE_ON: assert property (w_page |-> orb_word[`RMCB_PGS_HI:`RMCB_PGS_LO] == pgsz_reg)
    else $error("Page size not passed on with the page table flag.");
  AST_NO_SHORT: assert property (orb_valid |-> dsize_reg >= `RMCB_DSZ_MIN)
    else $error("Block in flight with a short data size.");
  AST_ERR_HOLD: assert property (err_reg && !clr_err |=> err_reg)
    else $error("Refusal flag lost without being cleared.");
  AST_WORD_HOLD: assert property (s_word_stalled |=> orb_valid && $stable(orb_word)
                                  && $stable(orb_last))
    else $error("Block word changed before it was accepted.");
  AST_FULL_BLOCK: assert property (s_block_end |-> chk_words_reg == `RMCB_W_LAST)
    else $error("Block ended without all of its words.");
  AST_STAT_HOLD: assert property (stat_ready && !stat_done |=> stat_ready)
    else $error("Host stopped waiting before the status block came in.");
  AST_DONE_SET: assert property (ce && stat_done |=> done_reg && !busy)
    else $error("Status block taken but done flag not set.");
  AST_DONE_HOLD: assert property (done_reg && !clr_done |=> done_reg)
    else $error("Done flag lost without being cleared.");
endmodule // rmcb_host_ctrl
`default_nettype wire

// ===== verif/rmcb_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmcb_map.svh"
module rmcb_dev_model (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic                 slow,
  input  wire logic                 orb_valid,
  output logic                      orb_ready,
  input  wire rmcb_pkg::rmcb_word_t orb_word,
  input  wire logic                 orb_last,
  output logic                      stat_valid,
  input  wire logic                 stat_ready,
  output rmcb_pkg::rmcb_word_t      stat_word,
  output logic                      stat_last,
  output rmcb_pkg::rmcb_word_t      blk [8]
);
  logic                 pend;
  logic [2:0]           idx;
  logic                 fields_ok;
  rmcb_pkg::rmcb_word_t verdict;

  // Constant fields of words 4 and 5 are checked, bits 23:16 of word 5 excepted; a page size is only allowed with the page table flag set.
  assign fields_ok = blk[4][31] && blk[4][30:28] == 3'h0 && blk[4][27] && blk[4][26:24] == 3'h2
                     && blk[4][23:20] == 4'h9 && (blk[4][19] || blk[4][18:16] == 3'h0)
                     && blk[4][15:0] >= 16'h0050 && blk[5][31:24] == 8'h20;
  assign verdict = fields_ok ? 32'h00000000 : 32'h00000001;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      orb_ready  <= 1'h0;
      idx        <= 3'h0;
      pend       <= 1'h0;
      stat_valid <= 1'h0;
      stat_last  <= 1'h0;
      stat_word  <= 32'h00000000;
      blk        <= '{default: 32'h00000000};
    end else begin
      // A slow device accepts only every other cycle, so the sender must hold its word.
      orb_ready <= slow ? ~orb_ready : 1'h1;
      if (orb_valid && orb_ready) begin
        blk[idx] <= orb_word;
        idx      <= idx + 3'h1;
        if (orb_last) begin
          pend <= 1'h1;
        end
      end
      if (pend && !stat_valid) begin
        stat_valid <= 1'h1;
        stat_word  <= verdict;
        pend       <= 1'h0;
      end else if (stat_valid && stat_ready) begin
        if (!stat_last) begin
          stat_word <= blk[4];
          stat_last <= 1'h1;
        end else begin
          // Released data lines must not keep looking valid.
          stat_valid <= 1'h0;
          stat_last  <= 1'h0;
          stat_word  <= ~stat_word;
        end
      end
    end
  end
endmodule  // rmcb_dev_model
`default_nettype wire

// ===== verif/rmcb_host_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmcb_map.svh"
module rmcb_host_ctrl_bench;
  logic                 sys_clk, rstn, hsel, hwrite, hready, hreadyout, hresp, slow, ce;
  logic [31:0]          haddr, hrdata;
  logic [1:0]           htrans;
  logic                 orb_valid, orb_ready, orb_last, stat_valid, stat_ready, stat_last;
  rmcb_pkg::rmcb_word_t hwdata, orb_word, stat_word, rd;
  rmcb_pkg::rmcb_word_t blk [8];
  int                   n_mismatch, checked;

  assign hready = hreadyout;
  always #10 sys_clk = ~sys_clk;

  rmcb_host_ctrl i_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .orb_valid(orb_valid),
    .orb_ready(orb_ready), .orb_word(orb_word), .orb_last(orb_last), .stat_valid(stat_valid),
    .stat_ready(stat_ready), .stat_word(stat_word), .stat_last(stat_last));

  rmcb_dev_model i_dev (.sys_clk(sys_clk), .rstn(rstn), .slow(slow), .orb_valid(orb_valid),
    .orb_ready(orb_ready), .orb_word(orb_word), .orb_last(orb_last), .stat_valid(stat_valid),
    .stat_ready(stat_ready), .stat_word(stat_word), .stat_last(stat_last), .blk(blk));

  task automatic chk(input rmcb_pkg::rmcb_word_t got, input rmcb_pkg::rmcb_word_t exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bus cycles start just after an edge and end on the edge where the answer is taken.
  task automatic bus(input logic wr, input logic [7:0] a, input rmcb_pkg::rmcb_word_t d);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hsel   <= 1'h0;
    if (wr) hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input rmcb_pkg::rmcb_word_t exp, input string w);
    bus(1'h0, a, 32'h00000000);
    chk(rd, exp, w);
  endtask

  function automatic rmcb_pkg::rmcb_word_t w4(input logic p, input logic [2:0] pg,
                                               input logic [15:0] ds);
    return {1'h1, 2'h0, 1'h0, 1'h1, 3'h2, 4'h9, p, (p ? pg : 3'h0), ds};
  endfunction

  task automatic issue(input logic p, input logic [2:0] pg, input logic [15:0] ds,
                       input logic [15:0] al, input rmcb_pkg::rmcb_word_t hi, lo);
    bus(1'h1, 8'h04, {29'h00000000, pg});
    bus(1'h1, 8'h08, {16'h0000, ds});
    bus(1'h1, 8'h0C, {16'h0000, al});
    bus(1'h1, 8'h10, hi);
    bus(1'h1, 8'h14, lo);
    bus(1'h1, 8'h00, {30'h00000000, p, 1'h1});
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'h0, 8'h18, 32'h00000000);
      n++;
    end while (rd[1] !== 1'h1 && n < 60);
  endtask

  task automatic chk_block(input logic p, input logic [2:0] pg, input logic [15:0] ds,
                           input logic [15:0] al, input rmcb_pkg::rmcb_word_t hi, lo);
    chk(blk[0], 32'h80000000, "next pointer");
    chk(blk[2], hi, "descriptor high");
    chk(blk[3], lo, "descriptor low");
    chk(blk[4], w4(p, pg, ds), "command word");
    chk(blk[5], {3'h1, 4'h0, 1'h0, 8'h00, al}, "unit word");
    rd_chk(8'h20, 32'h00000000, "status word 0");
    rd_chk(8'h24, w4(p, pg, ds), "status word 1");
  endtask

  task automatic t_reset_values();
    logic [7:0] offs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h40};
    foreach (offs[i]) rd_chk(offs[i], 32'h00000000, "reset or unmapped read");
    chk({31'h00000000, hresp}, 32'h00000000, "response code");
    $display("t_reset_values done");
  endtask

  task automatic t_block_p0();
    issue(1'h0, 3'h5, 16'h0050, 16'h1234, 32'hA5A50001, 32'h5A5A0100);
    wait_done();
    chk(rd, 32'h00010022, "status after first block");
    chk_block(1'h0, 3'h5, 16'h0050, 16'h1234, 32'hA5A50001, 32'h5A5A0100);
    bus(1'h1, 8'h18, 32'h00000006);
    bus(1'h0, 8'h18, 32'h00000000);
    chk(rd & 32'h00000007, 32'h00000000, "flags cleared");
    $display("t_block_p0 done");
  endtask

  task automatic t_block_p1_stall();
    slow <= 1'h1;
    issue(1'h1, 3'h5, 16'h0200, 16'h00C8, 32'h00000002, 32'hFFFF0000);
    bus(1'h1, 8'h04, 32'h00000000);
    rd_chk(8'h04, 32'h00000005, "config write while busy");
    rd_chk(8'h00, 32'h00000002, "control readback");
    wait_done();
    chk(rd, 32'h00020022, "status after second block");
    chk_block(1'h1, 3'h5, 16'h0200, 16'h00C8, 32'h00000002, 32'hFFFF0000);
    bus(1'h1, 8'h18, 32'h00000006);
    slow <= 1'h0;
    $display("t_block_p1_stall done");
  endtask

  task automatic t_short_size();
    issue(1'h0, 3'h0, 16'h004F, 16'h0010, 32'h00000000, 32'h00001000);
    bus(1'h0, 8'h18, 32'h00000000);
    chk(rd & 32'hFFFF0007, 32'h00020004, "short data size refused");
    bus(1'h1, 8'h18, 32'h00000006);
    rd_chk(8'h18, 32'h00020020, "error cleared");
    $display("t_short_size done");
  endtask

  // Bus cycles run while the enable is low, yet neither the write nor the GO may land.
  task automatic t_ce_freeze();
    ce <= 1'h0;
    bus(1'h1, 8'h04, 32'h00000007);
    bus(1'h1, 8'h00, 32'h00000003);
    ce <= 1'h1;
    rd_chk(8'h04, 32'h00000000, "page size frozen");
    rd_chk(8'h18, 32'h00020020, "no block or refusal while frozen");
    $display("t_ce_freeze done");
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'h0;
    rstn    = 1'h0;
    slow    = 1'h0;
    ce      = 1'h1;
    hsel    = 1'h0;
    hwrite  = 1'h0;
    htrans  = 2'h0;
    haddr   = 32'h00000000;
    hwdata  = 32'h00000000;
    n_mismatch = 0;
    checked    = 0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    t_reset_values();
    t_block_p0();
    t_block_p1_stall();
    t_short_size();
    t_ce_freeze();
    end_of_test();
  end

  // Whole run needs well under two thousand cycles; this span leaves ample margin.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule  // rmcb_host_ctrl_bench
`default_nettype wire
